// >>> verilog/crce_engine.sv
// crc engine top: sfr file, result pointer, automatic flash sweep
`timescale 1ns/100ps
`include "crce_defs.svh"

// Notes on behaviour
// - 16-bit mode msb-first, poly 0x1021
// - 16-bit: byte xored into upper byte
// - 16-bit: eight left shifts with poly
// - 32-bit mode reflected poly 0x04C11DB7
// - 32-bit: byte xored into low byte
// - 32-bit: eight right shifts, xor 0xEDB88320
// - select 0 picks 32-bit, 1 picks 16-bit
// - init select: zeros or ones start value
// - init bit write loads start value
// - each input write outside a sweep folds one byte
// - sector count, 1024 bytes per sector
// - control write with enable starts sweep
// - cpu stalled until sweep completes
// - result is 32 or 16 bits wide
// - data access hits pointed byte, increments
// - result held unless init, write, input, sweep fold
// - 16-bit pointer wraps bytes 0 and 1
module crce_engine #(
  parameter int ADDR_W = 17,  // flash byte address width
  parameter int PAGE_W = 6,   // start page field width
  parameter int CNT_W  = 8    // sector count width
) (
  input  wire logic                 core_clk,     // system clock, 25 MHz
  input  wire logic                 rstn,         // async reset, low active
  input  wire crce_pkg::crce_sfr_type sfr,        // sfr write/read strobes and data
  input  wire logic [1:0]           bank_select,  // code bank select for upper addresses
  output      logic [7:0]           crc_control_reg,   // control readback
  output      logic [7:0]           crc_input_reg,     // last input byte
  output      logic [7:0]           result_access_reg, // byte under the pointer
  output      logic [7:0]           auto_control_reg,  // automatic control readback
  output      logic [7:0]           sector_count_reg,  // sector count readback
  output      logic                 cpu_stall,    // hold instruction execution
  output      logic                 flash_rd,     // flash read strobe
  output      logic [ADDR_W-1:0]    flash_addr,   // flash byte address
  input  wire logic [7:0]           flash_rdata   // flash read data
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]             result_q, result_d;
  logic                    poly_select_q;
  logic                    init_value_select_q;
  logic [1:0]              result_byte_pointer_q, result_byte_pointer_d;
  logic [7:0]              input_q;
  logic                    auto_flash_enable_q;
  logic                    done_q, done_d;
  logic [PAGE_W-1:0]       start_page_q;
  logic [CNT_W-1:0]        count_q;
  crce_pkg::crce_state_type state_q, state_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [CNT_W+`CRCE_SECTOR_SHIFT-1:0] left_q, left_d;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire        busy        = (state_q != crce_pkg::CRCE_IDLE);
  wire        start_auto  = sfr.wr_ctrl && auto_flash_enable_q && !busy
                            && (count_q != '0);
  wire        do_init     = sfr.wr_ctrl && sfr.wdata[`CRCE_CTRL_INIT_BIT];
  wire        new_sel16   = sfr.wr_ctrl ? sfr.wdata[`CRCE_CTRL_SEL_BIT] : poly_select_q;
  wire        new_val     = sfr.wr_ctrl ? sfr.wdata[`CRCE_CTRL_VAL_BIT]
                                        : init_value_select_q;
  wire [31:0] init_value  = new_val ? `CRCE_INIT_ONES : `CRCE_INIT_ZEROS;
  wire [31:0] init_sized  = new_sel16 ? {16'h0000, init_value[15:0]}
                                      : init_value;
  wire [1:0]  ptr_eff     = poly_select_q ? {1'b0, result_byte_pointer_q[0]}
                                          : result_byte_pointer_q;
  wire [7:0]  ptr_byte    = result_q[8*ptr_eff +: 8];
  wire        ptr_access  = sfr.wr_data || sfr.rd_data;

  wire        rvalid;
  wire [7:0]  rbyte;
  wire        fold_auto   = (state_q == crce_pkg::CRCE_FOLD) && rvalid;
  wire        fold_any    = (sfr.wr_input && !busy) || fold_auto;
  wire [7:0]  fold_byte   = fold_auto ? rbyte : sfr.wdata;
  wire [31:0] fold_result;

  wire [ADDR_W-1:0] start_addr = ADDR_W'({bank_select, start_page_q,
                                 {`CRCE_SECTOR_SHIFT{1'b0}}});
  wire [CNT_W+`CRCE_SECTOR_SHIFT-1:0] start_left =
       {count_q, {`CRCE_SECTOR_SHIFT{1'b0}}};
  wire fetch_req = (state_q == crce_pkg::CRCE_FETCH);

  ////////////////////////////////////////////////////////////////////////////
  // byte fold and flash port
  crce_step u_step (
    .sel16   (poly_select_q),
    .crc_in  (result_q),
    .data_in (fold_byte),
    .crc_out (fold_result)
  );

  crce_flash_port #(.ADDR_W(ADDR_W)) u_flash (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .req         (fetch_req),
    .addr        (addr_q),
    .flash_rd    (flash_rd),
    .flash_addr  (flash_addr),
    .flash_rdata (flash_rdata),
    .rvalid      (rvalid),
    .rdata       (rbyte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result next value: init beats byte write beats fold; otherwise held
  always_comb begin
    result_d = result_q;
    if (do_init) begin
      result_d = init_sized;
    end else if (sfr.wr_data && !busy) begin
      result_d[8*ptr_eff +: 8] = sfr.wdata;
    end else if (fold_any) begin
      result_d = fold_result;
    end
  end

  always_comb begin
    result_byte_pointer_d = result_byte_pointer_q;
    if (sfr.wr_ctrl) begin
      result_byte_pointer_d = sfr.wdata[1:0];
    end else if (ptr_access && !busy) begin
      result_byte_pointer_d = result_byte_pointer_q + 2'b01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // automatic sweep: fetch one byte, fold it, advance
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    left_d  = left_q;
    done_d  = done_q;
    case (state_q)
      crce_pkg::CRCE_IDLE: begin
        if (start_auto) begin
          state_d = crce_pkg::CRCE_FETCH;
          addr_d  = start_addr;
          left_d  = start_left;
          done_d  = 1'b0;
        end
      end
      crce_pkg::CRCE_FETCH: begin
        state_d = crce_pkg::CRCE_FOLD;
      end
      crce_pkg::CRCE_FOLD: begin
        if (rvalid) begin
          addr_d = addr_q + ADDR_W'(1);
          left_d = left_q - 1'b1;
          if (left_q == {{(CNT_W+`CRCE_SECTOR_SHIFT-1){1'b0}}, 1'b1}) begin
            state_d = crce_pkg::CRCE_IDLE;
            done_d  = 1'b1;
          end else begin
            state_d = crce_pkg::CRCE_FETCH;
          end
        end
      end
      default: begin
        state_d = crce_pkg::CRCE_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flip-flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_q              <= `CRCE_INIT_ZEROS;
      result_byte_pointer_q <= 2'b00;
      state_q               <= crce_pkg::CRCE_IDLE;
      addr_q                <= '0;
      left_q                <= '0;
      done_q                <= 1'b1;
    end else begin
      result_q              <= result_d;
      result_byte_pointer_q <= result_byte_pointer_d;
      state_q               <= state_d;
      addr_q                <= addr_d;
      left_q                <= left_d;
      done_q                <= done_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      poly_select_q       <= 1'b0;
      init_value_select_q <= 1'b0;
    end else if (sfr.wr_ctrl) begin
      poly_select_q       <= sfr.wdata[`CRCE_CTRL_SEL_BIT];
      init_value_select_q <= sfr.wdata[`CRCE_CTRL_VAL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_q <= 8'h00;
    end else if (sfr.wr_input && !busy) begin
      input_q <= sfr.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      auto_flash_enable_q <= 1'b0;
      start_page_q        <= '0;
    end else if (sfr.wr_auto && !busy) begin
      auto_flash_enable_q <= sfr.wdata[`CRCE_AUTO_EN_BIT];
      start_page_q        <= sfr.wdata[PAGE_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (sfr.wr_count && !busy) begin
      count_q <= sfr.wdata[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cpu_stall         = busy || start_auto;
  assign crc_control_reg   = {3'b000, poly_select_q, 1'b0, init_value_select_q,
                              result_byte_pointer_q};
  assign crc_input_reg     = input_q;
  assign result_access_reg = ptr_byte;
  assign auto_control_reg  = 8'({auto_flash_enable_q, done_q, start_page_q});
  assign sector_count_reg  = 8'(count_q);
endmodule : crce_engine

// >>> shared/crce_defs.svh
// constants of the crc engine: field positions, reset values, polynomials, sector size
`ifndef CRCE_DEFS_SVH
`define CRCE_DEFS_SVH
`define CRCE_POLY16         16'h1021
`define CRCE_POLY32_REFL    32'hEDB88320
`define CRCE_INIT_ONES      32'hFFFFFFFF
`define CRCE_INIT_ZEROS     32'h00000000
`define CRCE_CTRL_SEL_BIT   4
`define CRCE_CTRL_INIT_BIT  3
`define CRCE_CTRL_VAL_BIT   2
`define CRCE_AUTO_EN_BIT    7
`define CRCE_AUTO_DONE_BIT  6
`define CRCE_SECTOR_BYTES   1024
`define CRCE_SECTOR_SHIFT   10
`define CRCE_AUTO_RESET     8'h40
`define CRCE_CTRL_RESET     8'h00
`define CRCE_CNT_RESET      8'h00
`endif

// >>> shared/crce_pkg.sv
// types of the crc engine
package crce_pkg;
  typedef enum logic [1:0] {
    CRCE_IDLE  = 2'b00,
    CRCE_FETCH = 2'b01,
    CRCE_FOLD  = 2'b10
  } crce_state_type;

  // one special-function-register access from the cpu
  typedef struct packed {
    logic       wr_ctrl;
    logic       wr_input;
    logic       wr_data;
    logic       rd_data;
    logic       wr_auto;
    logic       wr_count;
    logic [7:0] wdata;
  } crce_sfr_type;
endpackage : crce_pkg

// >>> verilog/crce_step.sv
// one-byte fold of either crc algorithm, combinational
`timescale 1ns/100ps
`include "crce_defs.svh"
module crce_step (
  input  wire logic        sel16,    // 1: 16-bit msb-first, 0: reflected 32-bit
  input  wire logic [31:0] crc_in,   // current result
  input  wire logic [7:0]  data_in,  // byte to fold
  output      logic [31:0] crc_out   // result after the byte
);
  logic [15:0] c16 [0:8];
  logic [31:0] c32 [0:8];

  assign c16[0] = crc_in[15:0] ^ {data_in, 8'h00};
  assign c32[0] = crc_in ^ {24'h000000, data_in};

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign c16[i+1] = c16[i][15] ? ({c16[i][14:0], 1'b0} ^ `CRCE_POLY16)
                                   : {c16[i][14:0], 1'b0};
      assign c32[i+1] = c32[i][0] ? ({1'b0, c32[i][31:1]} ^ `CRCE_POLY32_REFL)
                                  : {1'b0, c32[i][31:1]};
    end
  endgenerate

  assign crc_out = sel16 ? {16'h0000, c16[8]} : c32[8];
endmodule : crce_step

// >>> verilog/crce_flash_port.sv
// flash read port for the automatic mode: registered address, rvalid three cycles after req
`timescale 1ns/100ps
module crce_flash_port #(
  parameter int ADDR_W = 17
) (
  input  wire logic              core_clk,   // system clock
  input  wire logic              rstn,       // async reset, low active
  input  wire logic              req,        // read request this cycle
  input  wire logic [ADDR_W-1:0] addr,       // byte address
  output      logic              flash_rd,   // read strobe to the array
  output      logic [ADDR_W-1:0] flash_addr, // address to the array
  input  wire logic [7:0]        flash_rdata,// array data, valid cycle after strobe
  output      logic              rvalid,     // read data valid
  output      logic [7:0]        rdata       // registered read data
);
  logic              rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic              pend_q;
  logic              val_q;
  logic [7:0]        data_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q   <= 1'b0;
      addr_q <= '0;
    end else begin
      rd_q   <= req;
      addr_q <= req ? addr : addr_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      val_q  <= 1'b0;
      data_q <= 8'h00;
    end else begin
      // array answers in the cycle after the strobe, so capture one edge later
      pend_q <= rd_q;
      val_q  <= pend_q;
      data_q <= pend_q ? flash_rdata : data_q;
    end
  end

  assign flash_rd   = rd_q;
  assign flash_addr = addr_q;
  assign rvalid     = val_q;
  assign rdata      = data_q;
endmodule : crce_flash_port

// >>> bench/crce_props.sv
// port assertions of the crc engine
`timescale 1ns/100ps
module crce_props #(
  parameter int ADDR_W = 17
) (
  input wire logic                   core_clk,          // clock
  input wire logic                   rstn,              // reset
  input wire crce_pkg::crce_sfr_type sfr,               // strobes
  input wire logic [1:0]             bank_select,       // bank
  input wire logic [7:0]             crc_control_reg,   // control
  input wire logic [7:0]             crc_input_reg,     // input
  input wire logic [7:0]             result_access_reg, // result byte
  input wire logic [7:0]             auto_control_reg,  // auto
  input wire logic [7:0]             sector_count_reg,  // count
  input wire logic                   cpu_stall,         // stall
  input wire logic                   flash_rd,          // strobe
  input wire logic [ADDR_W-1:0]      flash_addr         // address
);
  logic [ADDR_W-1:0] prev_q;
  logic              seen_q;
  logic [17:0]       cnt_q;
  wire [ADDR_W-1:0] start_a = ADDR_W'({bank_select, auto_control_reg[5:0], 10'h000});
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= '0;
      seen_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      prev_q <= flash_rd ? flash_addr : prev_q;
      seen_q <= cpu_stall && (seen_q || flash_rd);
      cnt_q  <= !cpu_stall ? 18'h00000 : cnt_q + {17'h00000, flash_rd};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_start; $rose(cpu_stall); endsequence
  sequence s_quiet;
    !(sfr.wr_ctrl || sfr.wr_input || sfr.wr_data || sfr.rd_data) && !cpu_stall;
  endsequence
  property p_fields;
    sfr.wr_ctrl |=> crc_control_reg == {3'h0, $past(sfr.wdata[4]), 1'b0, $past(sfr.wdata[2:0])};
  endproperty
  a_fields: assert property (p_fields) else $error("control readback wrong");
  property p_init; sfr.wr_ctrl && sfr.wdata[3] |=> result_access_reg == {8{$past(sfr.wdata[2])}};
  endproperty
  a_init: assert property (p_init) else $error("init value wrong");
  property p_ptr;
    (sfr.rd_data || sfr.wr_data) && !cpu_stall
      |=> crc_control_reg[1:0] == $past(crc_control_reg[1:0]) + 2'h1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer did not advance");
  property p_hold; s_quiet |=> $stable(result_access_reg); endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_input; sfr.wr_input && !cpu_stall |=> crc_input_reg == $past(sfr.wdata); endproperty
  a_input: assert property (p_input) else $error("input byte lost");
  property p_stall;
    sfr.wr_ctrl && auto_control_reg[7] && sector_count_reg != 8'h00 |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("sweep did not stall");
  property p_first; s_start |-> ##[1:3] (flash_rd && flash_addr == start_a); endproperty
  a_first: assert property (p_first) else $error("first address wrong");
  property p_ascend; flash_rd && seen_q |-> flash_addr == prev_q + 1'b1; endproperty
  a_ascend: assert property (p_ascend) else $error("address not ascending");
  property p_count; $fell(cpu_stall) |-> cnt_q == {sector_count_reg, 10'h000}; endproperty
  a_count: assert property (p_count) else $error("byte count wrong");
  property p_done; $fell(cpu_stall) |-> ##[0:1] auto_control_reg[6]; endproperty
  a_done: assert property (p_done) else $error("done not set");
endmodule : crce_props
bind crce_engine crce_props #(.ADDR_W(ADDR_W)) u_crce_props (.core_clk(core_clk), .rstn(rstn),
  .sfr(sfr), .bank_select(bank_select), .crc_control_reg(crc_control_reg),
  .crc_input_reg(crc_input_reg), .result_access_reg(result_access_reg),
  .auto_control_reg(auto_control_reg), .sector_count_reg(sector_count_reg),
  .cpu_stall(cpu_stall), .flash_rd(flash_rd), .flash_addr(flash_addr));

// >>> bench/crce_flash_model.sv
// flash array model for the automatic sweep
`timescale 1ns/100ps
module crce_flash_model #(
  parameter int ADDR_W = 17
) (
  input  wire logic              core_clk,   // clock
  input  wire logic              flash_rd,   // read strobe
  input  wire logic [ADDR_W-1:0] flash_addr, // address
  output      logic [7:0]        flash_rdata // valid the cycle after the strobe
);
  initial flash_rdata = 8'hA5;
  // data only in the cycle after a strobe, scrambled otherwise
  always @(posedge core_clk) begin
    if (flash_rd) begin
      flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5A;
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : crce_flash_model

// >>> bench/crce_engine_bench.sv
// self-checking testbench of the crc engine
`timescale 1ns/100ps
module crce_engine_bench;
  logic                   core_clk;
  logic                   rstn;
  crce_pkg::crce_sfr_type sfr;
  logic [1:0]             bank_select;
  logic [7:0]             ctl, inr, res, aut, cnt, fdat, q;
  logic                   stall, frd;
  logic [16:0]            fadr, fa;
  logic [31:0]            c;
  int                     mismatches, checks_done, cycles, n;
  crce_engine u_crce_engine (.core_clk(core_clk), .rstn(rstn), .sfr(sfr),
    .bank_select(bank_select), .crc_control_reg(ctl), .crc_input_reg(inr),
    .result_access_reg(res), .auto_control_reg(aut), .sector_count_reg(cnt),
    .cpu_stall(stall), .flash_rd(frd), .flash_addr(fadr), .flash_rdata(fdat));
  crce_flash_model u_crce_flash_model (.core_clk(core_clk), .flash_rd(frd),
    .flash_addr(fadr), .flash_rdata(fdat));
  function automatic logic [31:0] fold(logic s16, logic [31:0] a, logic [7:0] d);
    if (s16) begin
      a[15:0] = a[15:0] ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) a[15:0] = {a[14:0], 1'b0} ^ (a[15] ? 16'h1021 : 16'h0000);
    end else begin
      a = a ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) a = (a >> 1) ^ (a[0] ? 32'hEDB88320 : 32'h00000000);
    end
    return a;
  endfunction : fold
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // k: 0 ctrl, 1 input, 2 data write, 3 data read, 4 auto, 5 count
  task automatic op(int k, logic [7:0] d);
    crce_pkg::crce_sfr_type v;
    v = '0;
    v.wdata = d;
    v.wr_ctrl = (k == 0);
    v.wr_input = (k == 1);
    v.wr_data = (k == 2);
    v.rd_data = (k == 3);
    v.wr_auto = (k == 4);
    v.wr_count = (k == 5);
    @(posedge core_clk);
    #1;
    sfr = v;
    #20;
    q = res;
    @(posedge core_clk);
    #1;
    sfr = '0;
  endtask : op
  task automatic rd4(string nm, logic s16, logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      op(3, 8'h00);
      chk(nm, s16 ? e[8*(i%2)+:8] : e[8*i+:8], q);
    end
  endtask : rd4
  task automatic give_verdict();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rstn = 1'b0;
    sfr = '0;
    bank_select = 2'b01;
    repeat (12) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk("ctrl", 8'h00, ctl);
    chk("auto", 8'h40, aut);
    chk("count", 8'h00, {cnt | inr});
    for (int s = 0; s < 2; s++) begin
      for (int v = 0; v < 2; v++) begin
        op(0, {3'h0, s[0], 1'b1, v[0], 2'h0});
        c = v ? 32'hFFFFFFFF : 32'h00000000;
        for (int j = 0; j < 3; j++) begin
          op(1, 8'hAA + 8'h11 * j[7:0]);
          c = fold(s[0], c, 8'hAA + 8'h11 * j[7:0]);
        end
        rd4("result", s[0], c);
      end
    end
    op(0, 8'h00);
    for (int j = 1; j < 5; j++) op(2, 8'h11 * j[7:0]);
    rd4("written", 1'b0, 32'h44332211);
    op(1, 8'h63);
    op(0, 8'h00);
    rd4("refold", 1'b0, fold(1'b0, 32'h44332211, 8'h63));
    op(0, 8'h0C);
    op(4, 8'h83);
    op(5, 8'h01);
    op(0, 8'h00);
    op(1, 8'h77);
    n = 0;
    while (stall !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    #1;
    chk("stall", 1'b0, stall);
    chk("done", 1'b1, aut[6]);
    op(4, 8'h03);
    chk("held input", 8'h63, inr);
    c = 32'hFFFFFFFF;
    for (int a = 0; a < 1024; a++) begin
      fa = {1'b1, 6'h03, a[9:0]};
      c = fold(1'b0, c, fa[7:0] ^ fa[15:8] ^ 8'h5A);
    end
    rd4("sweep", 1'b0, c);
    give_verdict();
  end
endmodule : crce_engine_bench
